/* File: rtl/adcsq_pkg.sv */
// Package: register map, field positions and timing constants of the conversion sequencer
package adcsq_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] ADCSQ_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCSQ_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCSQ_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] ADCSQ_OFF_RESH = 8'h0C;
  localparam logic [7:0] ADCSQ_OFF_RESL = 8'h10;
  localparam logic [7:0] ADCSQ_OFF_FLAG = 8'h14;
  localparam logic [7:0] ADCSQ_OFF_PMD = 8'h18;
  // Control register zero fields
  localparam int ADCSQ_BIT_ENABLE = 0;
  localparam int ADCSQ_BIT_GO = 1;
  localparam int ADCSQ_POS_CHS = 2;
  // Control register one fields
  localparam int ADCSQ_BIT_TRIGSRC = 7;
  localparam int ADCSQ_POS_VREF = 0;
  // Control register two fields
  localparam int ADCSQ_POS_CLKSEL = 0;
  localparam int ADCSQ_POS_ACQ = 3;
  localparam int ADCSQ_BIT_RIGHT = 7;
  // Flag register fields
  localparam int ADCSQ_BIT_DONE = 0;
  localparam int ADCSQ_BIT_IRQEN = 1;
  // Module disable register field
  localparam int ADCSQ_BIT_MDIS = 0;
  // Reset values
  localparam logic [7:0] ADCSQ_RST_REG = 8'h00;
  localparam logic [9:0] ADCSQ_RST_RESULT = 10'h000;
  // Timing in conversion bit periods
  localparam int ADCSQ_CONV_TAD = 11;
  localparam int ADCSQ_WAIT_TAD = 2;
  localparam int ADCSQ_FRC_DELAY_TAD = 1;
  // Sequencer states
  typedef enum logic [2:0] {
    ADCSQ_IDLE,
    ADCSQ_START_DLY,
    ADCSQ_ACQ,
    ADCSQ_CONV,
    ADCSQ_DISCHARGE,
    ADCSQ_OFF
  } adcsq_state_t;
endpackage : adcsq_pkg

/* File: rtl/adcsq_sequencer.sv */
// Conversion sequencer top: APB registers, start, acquire, convert, abort and sleep logic
// What this block does
// R01: Converter stays inactive until the enable bit is written one.
// R02: Start converts at once or after the programmed acquisition delay; code 010 is 4 periods.
// R03: With zero delay, conversion begins one instruction after start.
// R04: Software should enable and start in separate writes.
// R05: Completion clears busy, sets done flag, loads both result registers.
// R06: Capacitor array is discharged after every sample.
// R07: Clearing busy aborts; results keep the previous value.
// R08: Reset returns all registers to reset values and cancels conversion.
// R09: After completion or abort wait two periods before next acquisition.
// R10: Software adapts clock settings before power-managed use.
// R11: Below one megahertz software selects the RC clock.
// R12: RC clock selected delays conversion start by one extra instruction when the acquisition delay is zero.
// R13: In sleep with interrupt enabled, completion wakes the processor.
// R14: In sleep with interrupt off, power down after completion; enable stays set.
// R15: Sleep with non-RC clock aborts and powers down; enable stays set.
// R16: Trigger select picks compare unit at 0, charge-time unit at 1.
// R17: Accepted trigger while enabled sets busy and begins acquisition.
// R18: Triggers are ignored while the enable bit is zero.
// R19: Module disable holds converter in reset and gates its clock.
// R20: With zero delay software waits acquisition time itself.
// R21: Software clears the done flag after reading the result.
// R22: A full conversion takes exactly eleven bit periods.
// R23: Acquisition code 000 is manual, and is the reset value.
// R24: Nonzero acquisition delays span two to twenty bit periods.
// R25: Done flag stays set until software clears it.
// R26: Bit period comes from the divided system clock or the RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module adcsq_sequencer
  import adcsq_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Triggers and power state
  input wire logic compare_unit_trigger,
  input wire logic charge_time_unit,
  input wire logic sleep_active,
  input wire logic frc_tick,
  // Analog front end
  input wire logic [9:0] sar_value,
  output logic sample_connect,
  output logic discharge,
  output logic converting,
  output logic analog_powered,
  output logic [4:0] channel_select,
  // Processor wake
  output logic wake_request
);
  // Register state
  logic converter_enable, go_busy, trigger_source_select, right_justify;
  logic conversion_done_flag, conversion_irq_enable, converter_module_disable;
  logic [4:0] chs;
  logic [3:0] vref_cfg;
  logic [2:0] acquisition_delay_field, conversion_clock_select;
  logic [9:0] result;
  logic next_enable, next_go, next_trig, next_right, next_flag, next_irqen, next_mdis;
  logic [4:0] next_chs;
  logic [3:0] next_vref;
  logic [2:0] next_acq, next_clksel;
  logic [9:0] next_result;
  // Sequencer state
  adcsq_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic powered_down, next_powered_down;
  // Bus and output staging
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_wake;
  logic tad_tick, setup, wr, rd, go_written_one, go_written_zero, trig_hit, done_evt;

  adcsq_tad_gen u_tad
  (
    .clk_sys(clk_sys),
    .rstn(rstn && !converter_module_disable), // [R19]
    .ce(ce),
    .run(converter_enable && !converter_module_disable && state != ADCSQ_IDLE),
    .clk_select(conversion_clock_select),
    .frc_tick(frc_tick),
    .tad_tick(tad_tick)
  );

  // Acquisition periods for the select code
  function automatic logic [4:0] adcsq_acq_tads(input logic [2:0] code);
    unique case (code)
      3'h0: adcsq_acq_tads = 5'h00; // [R23]
      3'h1: adcsq_acq_tads = 5'h02; // [R24]
      3'h2: adcsq_acq_tads = 5'h04; // [R02]
      3'h3: adcsq_acq_tads = 5'h06;
      3'h4: adcsq_acq_tads = 5'h08;
      3'h5: adcsq_acq_tads = 5'h0C;
      3'h6: adcsq_acq_tads = 5'h10;
      3'h7: adcsq_acq_tads = 5'h14; // [R24]
    endcase
  endfunction : adcsq_acq_tads

  // Write one access phase, read in setup so data is ready at the access edge
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready;
  assign rd = setup && !pwrite;
  assign go_written_one = wr && paddr == ADCSQ_OFF_CTRL0 && pwdata[ADCSQ_BIT_GO];
  assign go_written_zero = wr && paddr == ADCSQ_OFF_CTRL0 && !pwdata[ADCSQ_BIT_GO];
  assign trig_hit = converter_enable && !go_busy && !powered_down // [R18]
    && (trigger_source_select ? charge_time_unit : compare_unit_trigger); // [R16]
  assign done_evt = state == ADCSQ_CONV && tad_tick
    && cnt == 5'(ADCSQ_CONV_TAD - 1) && !go_written_zero; // [R22]

  // Register file next values
  always_comb
  begin
    next_enable = converter_enable;
    next_go = go_busy;
    next_trig = trigger_source_select;
    next_right = right_justify;
    next_flag = conversion_done_flag;
    next_irqen = conversion_irq_enable;
    next_mdis = converter_module_disable;
    next_chs = chs;
    next_vref = vref_cfg;
    next_acq = acquisition_delay_field;
    next_clksel = conversion_clock_select;
    next_result = result;
    if (wr)
    begin
      unique case (paddr)
        ADCSQ_OFF_CTRL0:
        begin
          next_enable = pwdata[ADCSQ_BIT_ENABLE];
          // Start only honoured when already enabled
          next_go = pwdata[ADCSQ_BIT_GO] && converter_enable; // [R01] [R04] [R07]
          next_chs = pwdata[ADCSQ_POS_CHS +: 5];
        end
        ADCSQ_OFF_CTRL1:
        begin
          next_trig = pwdata[ADCSQ_BIT_TRIGSRC];
          next_vref = pwdata[ADCSQ_POS_VREF +: 4];
        end
        ADCSQ_OFF_CTRL2:
        begin
          next_right = pwdata[ADCSQ_BIT_RIGHT];
          next_acq = pwdata[ADCSQ_POS_ACQ +: 3];
          next_clksel = pwdata[ADCSQ_POS_CLKSEL +: 3];
        end
        ADCSQ_OFF_FLAG:
        begin
          next_flag = pwdata[ADCSQ_BIT_DONE]; // [R21] [R25]
          next_irqen = pwdata[ADCSQ_BIT_IRQEN];
        end
        ADCSQ_OFF_PMD: next_mdis = pwdata[ADCSQ_BIT_MDIS];
        default: ;
      endcase
    end
    if (trig_hit)
    begin
      next_go = 1'b1; // [R17]
    end
    if (done_evt)
    begin
      next_go = 1'b0; // [R05]
      next_flag = 1'b1; // [R05] [R25]
      next_result = sar_value; // [R05]
    end
    if (state == ADCSQ_OFF || next_powered_down)
    begin
      next_go = 1'b0; // [R15]
    end
    if (next_mdis)
    begin
      next_enable = 1'b0; // [R19]
      next_go = 1'b0;
      // Held in reset: converter fields fall back to their reset values
      next_trig = 1'b0; // [R19]
      next_right = 1'b0;
      next_chs = ADCSQ_RST_REG[4:0];
      next_vref = ADCSQ_RST_REG[3:0];
      next_acq = ADCSQ_RST_REG[2:0];
      next_clksel = ADCSQ_RST_REG[2:0];
      next_result = ADCSQ_RST_RESULT;
    end
  end

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_powered_down = powered_down && sleep_active;
    if (!converter_enable || converter_module_disable)
    begin
      next_state = ADCSQ_IDLE; // [R01] [R19]
      next_cnt = 5'h00;
    end
    else if (go_written_zero && go_busy && state != ADCSQ_DISCHARGE)
    begin
      next_state = ADCSQ_DISCHARGE; // [R07] [R09]
      next_cnt = 5'h00;
    end
    else if (sleep_active && conversion_clock_select[1:0] != 2'h3 && go_busy)
    begin
      next_state = ADCSQ_DISCHARGE; // [R15]
      next_powered_down = 1'b1;
      next_cnt = 5'h00;
    end
    else
    begin
      unique case (state)
        ADCSQ_IDLE:
        begin
          if (go_busy)
          begin
            next_cnt = 5'h00;
            // One instruction later; RC clock adds one more
            if (adcsq_acq_tads(acquisition_delay_field) != 5'h00)
            begin
              next_state = ADCSQ_ACQ; // [R02]
            end
            else
            begin
              next_state = ADCSQ_START_DLY; // [R03] [R20]
            end
          end
        end
        ADCSQ_START_DLY:
        begin
          if (tad_tick)
          begin
            next_cnt = cnt + 5'h01;
            if (conversion_clock_select[1:0] != 2'h3
              || cnt == 5'(ADCSQ_FRC_DELAY_TAD)) // [R12]
            begin
              next_state = ADCSQ_CONV;
              next_cnt = 5'h00;
            end
          end
        end
        ADCSQ_ACQ:
        begin
          if (tad_tick)
          begin
            next_cnt = cnt + 5'h01;
            if (cnt == adcsq_acq_tads(acquisition_delay_field) - 5'h01)
            begin
              next_state = ADCSQ_CONV; // [R02]
              next_cnt = 5'h00;
            end
          end
        end
        ADCSQ_CONV:
        begin
          if (tad_tick)
          begin
            next_cnt = cnt + 5'h01;
            if (done_evt)
            begin
              next_state = ADCSQ_DISCHARGE; // [R22]
              next_cnt = 5'h00;
              // Sleep with interrupt off powers the analog part down
              if (sleep_active && !conversion_irq_enable)
              begin
                next_powered_down = 1'b1; // [R14]
              end
            end
          end
        end
        ADCSQ_DISCHARGE:
        begin
          if (tad_tick)
          begin
            next_cnt = cnt + 5'h01;
            if (cnt == 5'(ADCSQ_WAIT_TAD - 1))
            begin
              next_state = ADCSQ_IDLE; // [R09]
              next_cnt = 5'h00;
            end
          end
        end
        ADCSQ_OFF: next_state = ADCSQ_IDLE;
      endcase
    end
  end

  // Bus answer and registered outputs
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_pready = setup;
    next_pslverr = 1'b0;
    if (setup)
    begin
      unique case (paddr)
        ADCSQ_OFF_CTRL0:
          next_prdata[7:0] = {1'b0, chs, go_busy, converter_enable};
        ADCSQ_OFF_CTRL1:
          next_prdata[7:0] = {trigger_source_select, 3'h0, vref_cfg};
        ADCSQ_OFF_CTRL2:
          next_prdata[7:0] = {right_justify, 1'b0, acquisition_delay_field, conversion_clock_select};
        ADCSQ_OFF_RESH:
          next_prdata[7:0] = right_justify ? {6'h00, result[9:8]} : result[9:2];
        ADCSQ_OFF_RESL:
          next_prdata[7:0] = right_justify ? result[7:0] : {result[1:0], 6'h00};
        ADCSQ_OFF_FLAG:
          next_prdata[7:0] = {6'h00, conversion_irq_enable, conversion_done_flag};
        ADCSQ_OFF_PMD:
          next_prdata[7:0] = {7'h00, converter_module_disable};
        default: next_pslverr = 1'b1;
      endcase
      if (!rd)
      begin
        next_prdata = 32'h0000_0000;
      end
    end
    next_wake = sleep_active && conversion_irq_enable && done_evt; // [R13]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      converter_enable <= 1'b0; // [R08]
      go_busy <= 1'b0;
      trigger_source_select <= 1'b0;
      right_justify <= 1'b0;
      conversion_done_flag <= 1'b0;
      conversion_irq_enable <= 1'b0;
      converter_module_disable <= 1'b0;
      chs <= ADCSQ_RST_REG[4:0];
      vref_cfg <= ADCSQ_RST_REG[3:0];
      acquisition_delay_field <= ADCSQ_RST_REG[2:0]; // [R23]
      conversion_clock_select <= ADCSQ_RST_REG[2:0];
      result <= ADCSQ_RST_RESULT;
      state <= ADCSQ_IDLE; // [R08]
      cnt <= 5'h00;
      powered_down <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      wake_request <= 1'b0;
      sample_connect <= 1'b0;
      discharge <= 1'b0;
      converting <= 1'b0;
      analog_powered <= 1'b0;
      channel_select <= 5'h00;
    end
    else if (ce)
    begin
      converter_enable <= next_enable;
      go_busy <= next_go;
      trigger_source_select <= next_trig;
      right_justify <= next_right;
      conversion_done_flag <= next_flag;
      conversion_irq_enable <= next_irqen;
      converter_module_disable <= next_mdis;
      chs <= next_chs;
      vref_cfg <= next_vref;
      acquisition_delay_field <= next_acq;
      conversion_clock_select <= next_clksel;
      result <= next_result;
      state <= next_state;
      cnt <= next_cnt;
      powered_down <= next_powered_down;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      wake_request <= next_wake;
      // Channel rides on the cap while enabled and not powered down, except while converting or discharging
      sample_connect <= next_enable && !next_powered_down
        && (next_state == ADCSQ_IDLE || next_state == ADCSQ_ACQ
        || next_state == ADCSQ_START_DLY); // [R09]
      discharge <= next_state == ADCSQ_DISCHARGE; // [R06]
      converting <= next_state == ADCSQ_CONV;
      analog_powered <= next_enable && !next_mdis && !next_powered_down; // [R14] [R15]
      channel_select <= next_chs;
    end
  end
endmodule : adcsq_sequencer
`default_nettype wire

/* File: rtl/adcsq_tad_gen.sv */
// Conversion bit period tick generator: divided system clock or RC oscillator
`timescale 1ns/1ns
`default_nettype none
module adcsq_tad_gen
  import adcsq_pkg::*;
(
  // Clock and control
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  // Clock selection and RC tick input
  input wire logic [2:0] clk_select,
  input wire logic frc_tick,
  // Period tick
  output logic tad_tick
);
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic next_tad_tick;

  // Divider terminal count from the select code
  function automatic logic [5:0] adcsq_div_last(input logic [2:0] sel);
    unique case (sel)
      3'h0: adcsq_div_last = 6'h01;
      3'h4: adcsq_div_last = 6'h03;
      3'h1: adcsq_div_last = 6'h07;
      3'h5: adcsq_div_last = 6'h0F;
      3'h2: adcsq_div_last = 6'h1F;
      3'h6: adcsq_div_last = 6'h3F;
      default: adcsq_div_last = 6'h00;
    endcase
  endfunction : adcsq_div_last

  always_comb
  begin
    next_div_cnt = div_cnt;
    next_tad_tick = 1'b0;
    if (!run)
    begin
      next_div_cnt = 6'h00;
    end
    else if (clk_select[1:0] == 2'h3)
    begin
      next_tad_tick = frc_tick; // [R26]
    end
    else if (div_cnt >= adcsq_div_last(clk_select))
    begin
      next_div_cnt = 6'h00;
      next_tad_tick = 1'b1; // [R26]
    end
    else
    begin
      next_div_cnt = div_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      div_cnt <= 6'h00;
      tad_tick <= 1'b0;
    end
    else if (ce)
    begin
      div_cnt <= next_div_cnt;
      tad_tick <= next_tad_tick;
    end
  end
endmodule : adcsq_tad_gen
`default_nettype wire

/* File: verif/adcsq_sequencer_assertions.sv */
// Checker: output timing relations of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module adcsq_seq_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched ports
  input wire logic pready,
  input wire logic sleep_active,
  input wire logic sample_connect,
  input wire logic discharge,
  input wire logic converting,
  input wire logic analog_powered,
  input wire logic wake_request
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_reset_clears_outputs: assert property (disable iff (1'b0)
    !rstn |=> !converting && !discharge && !wake_request && !analog_powered && !pready)
    else $error("outputs active after reset");
  a_power_for_conv: assert property ($rose(converting) |-> analog_powered)
    else $error("conversion started while unpowered");
  a_discharge_follows: assert property ($fell(converting) |-> ##[0:300] discharge)
    else $error("no discharge after conversion");
  a_sample_off_conv: assert property (converting |-> !sample_connect && !discharge)
    else $error("channel connected during conversion");
  a_discharge_isolated: assert property (discharge |-> !sample_connect)
    else $error("channel connected during discharge");
  // Shortest bit period is two cycles, so two periods never end sooner than this
  a_discharge_length: assert property ($rose(discharge) |-> discharge[*3])
    else $error("discharge too short");
  a_wake_in_sleep: assert property (wake_request |-> sleep_active && !converting)
    else $error("wake outside sleep");
  a_wake_single: assert property (wake_request |=> !wake_request)
    else $error("wake longer than one cycle");
endmodule : adcsq_seq_checker

bind adcsq_sequencer adcsq_seq_checker adcsq_seq_checker_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .pready(pready),
  .sleep_active(sleep_active),
  .sample_connect(sample_connect),
  .discharge(discharge),
  .converting(converting),
  .analog_powered(analog_powered),
  .wake_request(wake_request)
);
`default_nettype wire

/* File: verif/test_adc_conversion_sequencer.sv */
// Testbench: register-level scenarios of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module test_adc_conversion_sequencer
  import adcsq_pkg::*;
;
  logic clk_sys, rstn, ce, psel, penable, pwrite, pready, pslverr, frc_tick;
  logic compare_unit_trigger, charge_time_unit, sleep_active, wake_request;
  logic sample_connect, discharge, converting, analog_powered, conv_q, seen_conv, last_err;
  logic start_q;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [9:0] sar_value;
  logic [4:0] channel_select;
  logic [1:0] tick_div;
  int mismatches, tests_run, cycles, pre_ticks, conv_ticks, conv_cycles, wake_cnt, i;

  adcsq_sequencer adcsq_sequencer_inst (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_unit_trigger(compare_unit_trigger),
    .charge_time_unit(charge_time_unit), .sleep_active(sleep_active), .frc_tick(frc_tick),
    .sar_value(sar_value), .sample_connect(sample_connect), .discharge(discharge),
    .converting(converting), .analog_powered(analog_powered),
    .channel_select(channel_select), .wake_request(wake_request)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // RC oscillator stand-in: one tick every four cycles
  always @(posedge clk_sys)
  begin
    tick_div <= tick_div + 2'h1;
    frc_tick <= (tick_div == 2'h3);
  end

  // Counts bit periods before and during each conversion
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
    // Start is registered and idle exits one edge later: ticks there never count
    if (!converting && !seen_conv && frc_tick)
      pre_ticks++;
    if (start_q || (psel && penable && pready && pwrite && paddr == ADCSQ_OFF_CTRL0))
    begin
      pre_ticks = 0;
      seen_conv = 1'b0;
    end
    start_q = psel && penable && pready && pwrite && paddr == ADCSQ_OFF_CTRL0;
    if (converting && !conv_q)
    begin
      seen_conv = 1'b1;
      conv_ticks = 0;
      conv_cycles = 0;
    end
    if (converting)
      conv_cycles++;
    if (converting && frc_tick)
      conv_ticks++;
    if (wake_request)
      wake_cnt++;
    conv_q = converting;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      mismatches++;
    q = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ADCSQ_OFF_CTRL0, 8'h00);
      n++;
    end
    while (q[1] !== 1'b0 && n < 100);
    chk("busy", 8'h00, {7'h0, q[1]});
  endtask : wait_idle

  task automatic wait_conv;
    int n;
    n = 0;
    while (converting !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_conv

  task automatic pulse(input logic s);
    @(posedge clk_sys);
    charge_time_unit <= s;
    compare_unit_trigger <= !s;
    @(posedge clk_sys);
    charge_time_unit <= 1'b0;
    compare_unit_trigger <= 1'b0;
  endtask : pulse

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    compare_unit_trigger = 1'b0;
    charge_time_unit = 1'b0;
    sleep_active = 1'b0;
    sar_value = 10'h2A5;
    tick_div = 2'h0;
    frc_tick = 1'b0;
    conv_q = 1'b0;
    start_q = 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 7; i++)
      rd("reset value", 8'(4 * i), ADCSQ_RST_REG);
    apb(1'b0, 8'h1C, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, last_err});
    $display("test reset done");
    pulse(1'b0);
    rd("trigger while off", ADCSQ_OFF_CTRL0, 8'h00);
    wr(ADCSQ_OFF_CTRL0, 8'h03);
    rd("go with enable", ADCSQ_OFF_CTRL0, 8'h01);
    $display("test enable done");
    wr(ADCSQ_OFF_CTRL0, 8'h17);
    wait_idle();
    chk("conversion cycles", 8'h16, 8'(conv_cycles));
    chk("channel", 8'h05, {3'h0, channel_select});
    rd("flag", ADCSQ_OFF_FLAG, 8'h01);
    rd("result high", ADCSQ_OFF_RESH, 8'hA9);
    rd("result low", ADCSQ_OFF_RESL, 8'h40);
    repeat (20) @(posedge clk_sys);
    rd("flag held", ADCSQ_OFF_FLAG, 8'h01);
    wr(ADCSQ_OFF_FLAG, 8'h00);
    rd("flag cleared", ADCSQ_OFF_FLAG, 8'h00);
    $display("test divided clock done");
    sar_value <= 10'h155;
    for (i = 0; i < 2; i++)
    begin
      wr(ADCSQ_OFF_CTRL2, 8'h83 | 8'(16 * i));
      wr(ADCSQ_OFF_CTRL0, 8'h17);
      wait_idle();
      chk("start periods", 8'(2 + 2 * i), 8'(pre_ticks));
      chk("conversion periods", 8'h0B, 8'(conv_ticks));
      rd("right high", ADCSQ_OFF_RESH, 8'h01);
      rd("right low", ADCSQ_OFF_RESL, 8'h55);
    end
    $display("test acquisition done");
    wr(ADCSQ_OFF_FLAG, 8'h00);
    wr(ADCSQ_OFF_CTRL2, 8'h00);
    sar_value <= 10'h3FF;
    wr(ADCSQ_OFF_CTRL0, 8'h17);
    wait_conv();
    wr(ADCSQ_OFF_CTRL0, 8'h15);
    rd("abort control", ADCSQ_OFF_CTRL0, 8'h15);
    rd("kept high", ADCSQ_OFF_RESH, 8'h55);
    rd("kept low", ADCSQ_OFF_RESL, 8'h40);
    rd("no flag", ADCSQ_OFF_FLAG, 8'h00);
    chk("reconnected", 8'h01, {7'h0, sample_connect});
    $display("test abort done");
    for (i = 0; i < 2; i++)
    begin
      wr(ADCSQ_OFF_CTRL1, 8'(i * 128));
      pulse(!i[0]);
      repeat (4) @(posedge clk_sys);
      rd("other source", ADCSQ_OFF_CTRL0, 8'h15);
      pulse(i[0]);
      wait_idle();
      rd("trigger flag", ADCSQ_OFF_FLAG, 8'h01);
      wr(ADCSQ_OFF_FLAG, 8'h00);
      repeat (8) @(posedge clk_sys);
    end
    $display("test triggers done");
    wr(ADCSQ_OFF_PMD, 8'h01);
    rd("disabled control", ADCSQ_OFF_CTRL0, 8'h00);
    chk("disabled power", 8'h00, {7'h0, analog_powered});
    pulse(1'b0);
    rd("disabled trigger", ADCSQ_OFF_CTRL0, 8'h00);
    wr(ADCSQ_OFF_PMD, 8'h00);
    wr(ADCSQ_OFF_CTRL0, 8'h15);
    $display("test module disable done");
    for (i = 0; i < 2; i++)
    begin
      wr(ADCSQ_OFF_FLAG, i[0] ? 8'h00 : 8'h02);
      wr(ADCSQ_OFF_CTRL2, 8'h03);
      wake_cnt = 0;
      wr(ADCSQ_OFF_CTRL0, 8'h17);
      sleep_active <= 1'b1;
      wait_idle();
      repeat (12) @(posedge clk_sys);
      chk("wake count", 8'(1 - i), 8'(wake_cnt));
      chk("sleep power", 8'(1 - i), {7'h0, analog_powered});
      rd("sleep enable", ADCSQ_OFF_CTRL0, 8'h15);
      sleep_active <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    wr(ADCSQ_OFF_CTRL2, 8'h00);
    wr(ADCSQ_OFF_CTRL0, 8'h17);
    wait_conv();
    sleep_active <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("abort power", 8'h00, {7'h0, analog_powered});
    rd("abort enable", ADCSQ_OFF_CTRL0, 8'h15);
    sleep_active <= 1'b0;
    $display("test sleep done");
    wr(ADCSQ_OFF_CTRL0, 8'h17);
    wait_conv();
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("reset cancels", 8'h00, {7'h0, converting});
    rd("reset control", ADCSQ_OFF_CTRL0, 8'h00);
    $display("test reset in run done");
    test_done();
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
